/* src/psrc_pkg.sv */
// Package of constants for the power saving and reset control block
package psrc_pkg;
  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_POWER_MODE_CONTROL_0 = 8'h00;
  localparam logic [7:0] ADDR_POWER_MODE_CONTROL_2 = 8'h04;
  localparam logic [7:0] ADDR_CONFIG               = 8'h08;
  localparam logic [7:0] ADDR_STATUS               = 8'h0C;
  localparam logic [7:0] ADDR_MEMORY_MAP           = 8'h10;
  localparam logic [7:0] ADDR_USER_REG             = 8'h14;
  // ==========================================================
  // Field positions
  localparam int SPEED_BIT       = 3;
  localparam int AND_CLK_BLOCK   = 4;
  localparam int MC_CLK_BLOCK    = 5;
  localparam int CFG_APD_EN      = 0;
  localparam int CFG_STROBE_POL  = 1;
  localparam int MAP_SRAM_CODE   = 0;
  localparam int MAP_PERIPH_MODE = 1;
  // ==========================================================
  // Reset values
  localparam logic [7:0] POWER_MODE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET     = 8'h00;
  localparam logic [7:0] MAP_DEFAULT      = 8'h00;
  // POWER_MODE_CONTROL_2 bits that gate inputs: 0,2,3,4,5,6
  localparam logic [7:0] GATE_MASK_2      = 8'h7D;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ          = 25;
  localparam int IDLE_CYCLES      = 15;
  localparam int STANDBY_NS       = 70;
  localparam int STANDBY_CYCLES   = (STANDBY_NS * CLK_MHZ + 999) / 1000;
  localparam int POST_RESET_NS    = 120;
  localparam int POST_RESET_CYCLES = (POST_RESET_NS * CLK_MHZ) / 1000;
  localparam int POWER_ON_US      = 1000;
  localparam int POWER_ON_CYCLES  = POWER_ON_US * CLK_MHZ;
  localparam int ABORT_US         = 25;
  localparam int ABORT_CYCLES     = ABORT_US * CLK_MHZ;
  localparam int CNT_W            = 16;

  typedef enum logic [1:0] {ST_CONFIG, ST_WAIT, ST_RUN} psrc_state_t;
endpackage : psrc_pkg

/* src/psrc_power_reset.sv */
// Power saving and reset control top module
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
// What this block does
// - Speed bit set: idle inputs give standby after 70ns
// - Speed bit clear: full power, full speed default
// - Slow mode may lengthen delay below 15MHz
// - Chip select low enables memories and I/O
// - Chip select high disables flashes and SRAM
// - Control0 bits 4/5 block logic clock paths
// - Control2 bits 0,2-6 block address/control inputs
// - Idle counter flags power-down after 15 cycles
// - Power-on reset loads config, clears, flash operates
// - Stay in reset 120ns after release
// - Flash comes up in read mode
// - Sector selects low, write strobe high at power-on
// - Reset aborts program/erase, returns to read mode
// - Logic outputs valid in warm reset
// - MCU I/O pins to input; held in power-down
// - Address out, data, peripheral pins tri-stated
// - Control0/2 cleared only by power-on reset
// - Macrocells cleared at power-on, else user equations
// - Memory map reloaded, two bits cleared
// - Strobe, chip select or reset wake power-down
// - Idle counter keeps its clock when logic blocked
module psrc_power_reset #(
  parameter int POWER_ON_CYCLES = psrc_pkg::POWER_ON_CYCLES,
  parameter int MC_W            = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Device pins (asynchronous)
  input  wire logic              warmReset_n,
  input  wire logic              chipSelect_n,
  input  wire logic              addressStrobe,
  input  wire logic              logicInputClock,
  input  wire logic              highByteWrite,
  input  wire logic [7:0]        lowAddress,
  input  wire logic [2:0]        controlLines,
  // Flash state machine interface
  input  wire logic              flashBusy,
  output logic                   flashAbort,
  output logic                   flashReadMode,
  output logic                   sectorSelectHold,
  output logic                   writeStrobeHold,
  // Memory enables
  output logic                   memEnable,
  output logic                   ioEnable,
  // Logic array controls
  output logic                   fullSpeed,
  output logic                   logicStandby,
  output logic                   andClockEnable,
  output logic                   macrocellClockEnable,
  output logic [7:0]             gatedLowAddress,
  output logic [2:0]             gatedControl,
  output logic                   gatedStrobe,
  output logic                   gatedHighByteWrite,
  // Macrocells with user equations
  input  wire logic [MC_W-1:0]   mcData,
  input  wire logic [MC_W-1:0]   userResetEquation,
  input  wire logic [MC_W-1:0]   userPresetEquation,
  output logic      [MC_W-1:0]   outputMacrocell,
  // Port control and status
  output logic                   ioForceInput,
  output logic                   tristatePorts,
  output logic                   powerdownFlag,
  output logic                   deviceReady
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0]               wrS, csS, asS, lcS;
    logic [2:0]               hbS;
    logic [7:0]               pm0, pm2, cfg, memMap, userReg;
    logic [3:0]               idle;
    logic                     powerdown_flag;
    logic [psrc_pkg::CNT_W-1:0] cnt;
    logic [15:0]              abortCnt;
    logic                     abortAct;
    logic [3:0]               stby;
    psrc_pkg::psrc_state_t    st;
    logic [MC_W-1:0]          mc;
    logic [31:0]              rdata;
  } psrc_regs_t;

  psrc_regs_t r, next_r;
  logic wrm, cs, asLvl, asEdge, lcEdge, busWr, busRd, wakeUp;

  // ==========================================================
  // Pins: three-stage sync, change detected when stages 2 and 3 differ
  assign wrm    = ~r.wrS[1];
  assign cs     = ~r.csS[1];
  assign asLvl  = r.asS[1];
  assign asEdge = r.asS[1] ^ r.asS[2];
  assign lcEdge = r.lcS[1] & ~r.lcS[2];
  assign busWr  = psel & penable & pwrite;
  assign busRd  = psel & penable & ~pwrite;
  assign wakeUp = asEdge | cs | wrm;

  always_comb begin
    next_r = r;
    next_r.wrS = {r.wrS[1:0], warmReset_n};
    next_r.csS = {r.csS[1:0], chipSelect_n};
    next_r.asS = {r.asS[1:0], addressStrobe};
    next_r.lcS = {r.lcS[1:0], logicInputClock};
    next_r.hbS = {r.hbS[1:0], highByteWrite};
    // Reset sequencing
    case (r.st)
      psrc_pkg::ST_CONFIG: begin
        if (r.cnt >= psrc_pkg::CNT_W'(POWER_ON_CYCLES - 1)) begin
          next_r.cnt = '0;
          next_r.st  = psrc_pkg::ST_WAIT;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      psrc_pkg::ST_WAIT: begin
        if (wrm) begin
          next_r.cnt = '0;
        end else if (r.cnt >= psrc_pkg::CNT_W'(psrc_pkg::POST_RESET_CYCLES - 1)) begin
          next_r.st = psrc_pkg::ST_RUN;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      psrc_pkg::ST_RUN: begin
        if (wrm) begin
          next_r.cnt = '0;
          next_r.st  = psrc_pkg::ST_WAIT;
        end
      end
      default: next_r.st = psrc_pkg::ST_CONFIG;
    endcase
    // Warm reset: clear ordinary registers, reload map, keep pm0/pm2
    if (wrm) begin
      next_r.cfg     = psrc_pkg::CONFIG_RESET;
      next_r.userReg = '0;
      next_r.memMap  = psrc_pkg::MAP_DEFAULT;
      next_r.memMap[psrc_pkg::MAP_SRAM_CODE]   = 1'b0;
      next_r.memMap[psrc_pkg::MAP_PERIPH_MODE] = 1'b0;
      next_r.powerdown_flag  = 1'b0;
      next_r.idle = '0;
      if (flashBusy & ~r.abortAct) begin
        next_r.abortAct = 1'b1;
        next_r.abortCnt = '0;
      end
    end
    // Abort timer runs to its minimum then drops
    if (r.abortAct) begin
      if (r.abortCnt >= 16'(psrc_pkg::ABORT_CYCLES - 1)) begin
        next_r.abortAct = 1'b0;
      end else begin
        next_r.abortCnt = r.abortCnt + 1'b1;
      end
    end
    // Idle counter runs on logic input clock edges, never blocked
    if (!r.cfg[psrc_pkg::CFG_APD_EN] || asEdge) begin
      next_r.idle = '0;
    end else if (asLvl == r.cfg[psrc_pkg::CFG_STROBE_POL] && lcEdge && !r.powerdown_flag) begin
      if (r.idle == 4'(psrc_pkg::IDLE_CYCLES - 1)) begin
        next_r.powerdown_flag = 1'b1;
      end
      next_r.idle = r.idle + 1'b1;
    end
    if (r.powerdown_flag && wakeUp) begin
      next_r.powerdown_flag  = 1'b0;
      next_r.idle = '0;
    end
    // Standby timer for slow mode
    if (lcEdge || asEdge || r.hbS[1] != r.hbS[2]) begin
      next_r.stby = '0;
    end else if (r.stby != 4'(psrc_pkg::STANDBY_CYCLES)) begin
      next_r.stby = r.stby + 1'b1;
    end
    // Macrocells: user equations outside power-on reset
    for (int i = 0; i < MC_W; i++) begin
      if (userResetEquation[i]) begin
        next_r.mc[i] = 1'b0;
      end else if (userPresetEquation[i]) begin
        next_r.mc[i] = 1'b1;
      end else if (lcEdge && r.pm0[psrc_pkg::MC_CLK_BLOCK] == 1'b0) begin
        next_r.mc[i] = mcData[i];
      end
    end
    // APB register access
    if (busWr && r.st == psrc_pkg::ST_RUN) begin
      case (paddr)
        psrc_pkg::ADDR_POWER_MODE_CONTROL_0: next_r.pm0     = pwdata[7:0];
        psrc_pkg::ADDR_POWER_MODE_CONTROL_2: next_r.pm2     = pwdata[7:0];
        psrc_pkg::ADDR_CONFIG:               next_r.cfg     = pwdata[7:0];
        psrc_pkg::ADDR_MEMORY_MAP:           next_r.memMap  = pwdata[7:0];
        psrc_pkg::ADDR_USER_REG:             next_r.userReg = pwdata[7:0];
        default: ;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        psrc_pkg::ADDR_POWER_MODE_CONTROL_0: next_r.rdata = {24'h00_0000, r.pm0};
        psrc_pkg::ADDR_POWER_MODE_CONTROL_2: next_r.rdata = {24'h00_0000, r.pm2};
        psrc_pkg::ADDR_CONFIG:               next_r.rdata = {24'h00_0000, r.cfg};
        psrc_pkg::ADDR_STATUS:               next_r.rdata = {28'h000_0000, r.abortAct,
                                                  r.st == psrc_pkg::ST_RUN, logicStandby, r.powerdown_flag};
        psrc_pkg::ADDR_MEMORY_MAP:           next_r.rdata = {24'h00_0000, r.memMap};
        psrc_pkg::ADDR_USER_REG:             next_r.rdata = {24'h00_0000, r.userReg};
        default:                             next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // Power-on reset clears everything but the warm reset and chip select syncs, which load ones; pm0/pm2 and macrocells included
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r        <= '0;
      r.wrS    <= 3'b111;
      r.csS    <= 3'b111;
      r.memMap <= psrc_pkg::MAP_DEFAULT;
      r.st     <= psrc_pkg::ST_CONFIG;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  logic unmapped;
  assign unmapped = !(paddr inside {psrc_pkg::ADDR_POWER_MODE_CONTROL_0, psrc_pkg::ADDR_POWER_MODE_CONTROL_2,
                      psrc_pkg::ADDR_CONFIG, psrc_pkg::ADDR_STATUS, psrc_pkg::ADDR_MEMORY_MAP,
                      psrc_pkg::ADDR_USER_REG});
  assign prdata  = r.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & unmapped;
  assign deviceReady      = (r.st == psrc_pkg::ST_RUN);
  assign flashAbort       = r.abortAct;
  assign flashReadMode    = (r.st != psrc_pkg::ST_RUN) | r.abortAct;
  assign sectorSelectHold = (r.st == psrc_pkg::ST_CONFIG);
  assign writeStrobeHold  = (r.st == psrc_pkg::ST_CONFIG);
  assign memEnable = cs & ~r.powerdown_flag & deviceReady;
  assign ioEnable  = cs & deviceReady;
  assign fullSpeed    = ~r.pm0[psrc_pkg::SPEED_BIT];
  assign logicStandby = r.pm0[psrc_pkg::SPEED_BIT] & (r.stby == 4'(psrc_pkg::STANDBY_CYCLES));
  assign andClockEnable       = ~r.pm0[psrc_pkg::AND_CLK_BLOCK];
  assign macrocellClockEnable = ~r.pm0[psrc_pkg::MC_CLK_BLOCK];
  // Strobe and high byte write gating uses the synchronised copies; address and control lines are gated unsynchronised
  assign gatedLowAddress    = r.pm2[0] ? 8'h00 : lowAddress;
  assign gatedControl       = {r.pm2[3] ? 1'b0 : controlLines[2],
                               r.pm2[2] ? 1'b0 : controlLines[1], controlLines[0]};
  assign gatedStrobe        = r.pm2[4] ? 1'b0 : asLvl;
  assign gatedHighByteWrite = (r.pm2[5] | r.pm2[6]) ? 1'b0 : r.hbS[1];
  assign outputMacrocell    = r.mc;
  assign ioForceInput  = (r.st != psrc_pkg::ST_RUN);
  assign tristatePorts = (r.st != psrc_pkg::ST_RUN) | r.powerdown_flag;
  assign powerdownFlag = r.powerdown_flag;
endmodule : psrc_power_reset

/* tb/psrc_checker_assertions.sv */
// Checker with concurrent assertions on the top module ports
`timescale 1ns/1ps
module psrc_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Bus
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  // Pins and status
  input wire logic       chipSelect_n,
  input wire logic       warmReset_n,
  input wire logic       memEnable,
  input wire logic       deviceReady,
  input wire logic       ioForceInput,
  input wire logic       tristatePorts,
  input wire logic       logicStandby,
  input wire logic       fullSpeed,
  input wire logic       powerdownFlag,
  input wire logic       flashAbort,
  input wire logic       flashReadMode,
  input wire logic [7:0] lowAddress,
  input wire logic [7:0] gatedLowAddress,
  input wire logic       sectorSelectHold,
  input wire logic       writeStrobeHold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Sequences
  // Sync flops need a few cycles, so a level must stand first
  sequence s_deselected; chipSelect_n[*4]; endsequence
  sequence s_warm_held;  !warmReset_n[*5]; endsequence
  // ==========================================================
  // Properties
  a_bus_answer:   assert property (psel && penable |-> pready) else $error("no ready in access");
  a_bus_unmapped: assert property (psel && penable && paddr > 8'h14 |-> pslverr) else $error("no error on unmapped");
  a_mem_deselect: assert property (s_deselected |-> !memEnable) else $error("memory on while deselected");
  a_mem_ready:    assert property (memEnable |-> deviceReady && !powerdownFlag) else $error("memory on early");
  a_warm_ports:   assert property (s_warm_held |-> ioForceInput && tristatePorts && !deviceReady)
    else $error("ports not safe in reset");
  a_standby_slow: assert property (logicStandby |-> !fullSpeed) else $error("standby at full speed");
  a_abort_read:   assert property (flashAbort |-> flashReadMode) else $error("abort without read mode");
  a_gate_pass:    assert property (gatedLowAddress == lowAddress || gatedLowAddress == 8'h00)
    else $error("gated address corrupt");
  a_config_hold:  assert property (sectorSelectHold |-> writeStrobeHold && !deviceReady)
    else $error("selects not held");
endmodule : psrc_checker
bind psrc_power_reset psrc_checker i_chk (.clk, .rst_n, .psel, .penable, .paddr, .pready, .pslverr, .chipSelect_n,
  .warmReset_n, .memEnable, .deviceReady, .ioForceInput, .tristatePorts, .logicStandby, .fullSpeed, .powerdownFlag,
  .flashAbort, .flashReadMode, .lowAddress, .gatedLowAddress, .sectorSelectHold, .writeStrobeHold);

/* tb/psrc_mcu_model.sv */
// Microcontroller-side model of address strobe and logic clock
`timescale 1ns/1ps
module psrc_mcu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench controls
  input  wire logic runClock,
  input  wire logic pulseStrobe,
  // Pins toward device
  output logic      logicInputClock,
  output logic      addressStrobe
);
  // Logic clock stands low outside bursts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      logicInputClock <= 1'b0;
      addressStrobe   <= 1'b0;
    end else begin
      logicInputClock <= runClock & ~logicInputClock;
      addressStrobe   <= pulseStrobe & ~addressStrobe;
    end
  end
endmodule : psrc_mcu_model

/* tb/testbench.sv */
// Self-checking bench for the power saving and reset control block
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, warmReset_n = 1, chipSelect_n = 0;
  logic highByteWrite = 0, flashBusy = 0, runClock = 0, pulseStrobe = 0, e;
  logic [7:0] paddr = 0, lowAddress = 0;
  logic [2:0] controlLines = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [15:0] mcData = 0, userResetEquation = 0, userPresetEquation = 0;
  logic pready, pslverr, addressStrobe, logicInputClock, flashAbort, flashReadMode, sectorSelectHold;
  logic writeStrobeHold, memEnable, ioEnable, fullSpeed, logicStandby, andClockEnable, macrocellClockEnable;
  logic gatedStrobe, gatedHighByteWrite, ioForceInput, tristatePorts, powerdownFlag, deviceReady;
  logic [7:0] gatedLowAddress;
  logic [2:0] gatedControl;
  logic [15:0] outputMacrocell;
  int n_fail = 0, check_count = 0;
  always #20 clk = ~clk;
  psrc_mcu_model i_mcu (.clk, .rst_n, .runClock, .pulseStrobe, .logicInputClock, .addressStrobe);
  psrc_power_reset #(.POWER_ON_CYCLES(20)) i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .warmReset_n, .chipSelect_n, .addressStrobe, .logicInputClock, .highByteWrite,
    .lowAddress, .controlLines, .flashBusy, .flashAbort, .flashReadMode, .sectorSelectHold, .writeStrobeHold,
    .memEnable, .ioEnable, .fullSpeed, .logicStandby, .andClockEnable, .macrocellClockEnable, .gatedLowAddress,
    .gatedControl, .gatedStrobe, .gatedHighByteWrite, .mcData, .userResetEquation, .userPresetEquation,
    .outputMacrocell, .ioForceInput, .tristatePorts, .powerdownFlag, .deviceReady);
  // ==========================================================
  // Common tasks
  task complete_run;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // Bounded wait on ready; data taken at the same edge
    for (int n = 0; n <= 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
      if (n == 20) begin n_fail++; complete_run(); end
    end
    q = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task wait_ready;
    for (int n = 0; deviceReady !== 1'b1; n++) begin
      @(negedge clk);
      if (n == 200) begin n_fail++; complete_run(); end
    end
  endtask : wait_ready
  // ==========================================================
  // Scenarios
  task t_reset;
    repeat (2) @(negedge clk);
    chk("hold", {sectorSelectHold, writeStrobeHold, deviceReady, flashReadMode}, 32'h0000_000D);
    chk("mc por", outputMacrocell, 32'h0000_0000);
    chk("full", {fullSpeed, logicStandby}, 32'h0000_0002);
    wait_ready();
    apb(0, psrc_pkg::ADDR_POWER_MODE_CONTROL_0, 0); chk("pm0", q, 32'h0000_0000);
    apb(0, psrc_pkg::ADDR_POWER_MODE_CONTROL_2, 0); chk("pm2", q, 32'h0000_0000);
    apb(0, 8'h40, 0); chk("unmapped", {e, q[30:0]}, 32'h8000_0000);
  endtask : t_reset
  task t_power_bits;
    lowAddress <= 8'hA5; controlLines <= 3'h7; highByteWrite <= 1;
    apb(1, psrc_pkg::ADDR_POWER_MODE_CONTROL_0, 32'h0000_0038);
    apb(0, psrc_pkg::ADDR_POWER_MODE_CONTROL_0, 0); chk("pm0 rw", q, 32'h0000_0038);
    repeat (6) @(negedge clk);
    chk("speed", {fullSpeed, logicStandby, andClockEnable, macrocellClockEnable}, 32'h0000_0004);
    apb(1, psrc_pkg::ADDR_POWER_MODE_CONTROL_2, 32'h0000_007D);
    @(negedge clk);
    chk("gated", {gatedLowAddress, gatedControl[2:1], gatedStrobe, gatedHighByteWrite}, 32'h0000_0000);
    apb(1, psrc_pkg::ADDR_POWER_MODE_CONTROL_2, 0);
    @(negedge clk);
    chk("open", gatedLowAddress, 32'h0000_00A5);
  endtask : t_power_bits
  task t_chip_select;
    @(posedge clk);
    chipSelect_n <= 1;
    repeat (5) @(negedge clk);
    chk("cs high", {memEnable, ioEnable}, 32'h0000_0000);
    @(posedge clk);
    chipSelect_n <= 0;
    repeat (5) @(negedge clk);
    chk("cs low", {memEnable, ioEnable}, 32'h0000_0003);
  endtask : t_chip_select
  task t_idle;
    // Strobe held low, polarity 0; logic clock blocked from the array
    // Chip select held high, since a low select would wake at once
    apb(1, psrc_pkg::ADDR_CONFIG, 32'h0000_0001);
    runClock <= 1;
    chipSelect_n <= 1;
    mcData <= 16'hFFFF;
    // Fifteenth logic clock rise lands 29 cycles after the config write, the flag 32
    repeat (32) @(negedge clk);
    chk("early", powerdownFlag, 32'h0000_0000);
    @(negedge clk);
    chk("pdn", {powerdownFlag, memEnable}, 32'h0000_0002);
    apb(0, psrc_pkg::ADDR_STATUS, 0); chk("status", q, 32'h0000_0005);
    pulseStrobe <= 1;
    repeat (8) @(negedge clk);
    chk("wake", powerdownFlag, 32'h0000_0000);
    chk("mc blocked", outputMacrocell, 32'h0000_0000);
    @(posedge clk);
    pulseStrobe <= 0;
    runClock <= 0;
    chipSelect_n <= 0;
  endtask : t_idle
  task t_warm;
    apb(1, psrc_pkg::ADDR_MEMORY_MAP, 32'h0000_00FF);
    flashBusy <= 1; warmReset_n <= 0;
    userPresetEquation <= 16'h00FF;
    repeat (6) @(negedge clk);
    chk("warm", {flashAbort, flashReadMode, ioForceInput, tristatePorts, deviceReady}, 32'h0000_001E);
    chk("mc warm", outputMacrocell, 32'h0000_00FF);
    @(posedge clk);
    warmReset_n <= 1;
    flashBusy <= 0;
    userPresetEquation <= 0;
    wait_ready();
    apb(0, psrc_pkg::ADDR_POWER_MODE_CONTROL_0, 0); chk("pm0 kept", q, 32'h0000_0038);
    apb(0, psrc_pkg::ADDR_CONFIG, 0); chk("cfg clr", q, 32'h0000_0000);
    apb(0, psrc_pkg::ADDR_MEMORY_MAP, 0); chk("map", q, {24'h00_0000, psrc_pkg::MAP_DEFAULT & 8'hFC});
  endtask : t_warm
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_power_bits();
    t_chip_select();
    t_idle();
    t_warm();
    complete_run();
  end
endmodule : testbench
